/* rftx_consts.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the pulse shaper and timing modules
`ifndef RFTX_CONSTS_SVH
`define RFTX_CONSTS_SVH
// Register offsets
`define RFTX_ADDR_PULSE 8'h2f
`define RFTX_ADDR_BURST 8'h30
`define RFTX_ADDR_WCTRL 8'h31
`define RFTX_ADDR_WLOW 8'h32
`define RFTX_ADDR_STATUS 8'h3f
// Wait control fields
`define RFTX_WC_ORIGIN 7
`define RFTX_WC_UNIT 6
`define RFTX_WC_UP_HI 5
`define RFTX_WC_UP_LO 3
`define RFTX_WC_STOP_HI 2
// Burst length fields
`define RFTX_BL_ONE_HI 6
`define RFTX_BL_ONE_LO 4
`define RFTX_BL_ZERO_HI 2
// Reset values
`define RFTX_RST_WCTRL 8'hc0
`define RFTX_RST_ZERO 8'h00
// Carrier periods per wait unit when the unit select is clear
`define RFTX_CARRIER_PER_UNIT 16
`endif

/* rftx_field_model.sv */
// Far-side timing model: carrier, half-bit and bit ticks, end of reception
// Assumes the same clock as the timing block; all outputs are one-cycle pulses
`timescale 1ns/1ps
module rftx_field_model
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic rx_req_in,
    output logic carrier_tick_out,
    output logic half_bit_tick_out,
    output logic bit_tick_out,
    output logic rx_end_out
);
    logic [3:0] cyc_r;
    // Free-running tick phase, reception end one cycle after request
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            cyc_r <= 4'h0;
            rx_end_out <= 1'b0;
        end
        else
        begin
            cyc_r <= (cyc_r == 4'h5) ? 4'h0 : cyc_r + 4'h1;
            rx_end_out <= rx_req_in;
        end
    end
    // Carrier every 2 cycles, bit timing every 3
    assign carrier_tick_out = cyc_r[0];
    assign half_bit_tick_out = (cyc_r == 4'h2) || (cyc_r == 4'h5);
    assign bit_tick_out = (cyc_r == 4'h1) || (cyc_r == 4'h4);
endmodule

/* rftx_pkg.sv */
// Types shared by the transmit timing block and its pulse shaper
// Assumes the constants header sits in the same folder
package rftx_pkg;
    // Wait state, one-hot
    typedef enum logic [1:0] {
        RFTX_W_READY = 2'b01,
        RFTX_W_COUNT = 2'b10
    } rftx_wstate_t;

    // Pulse shaper state
    typedef struct packed {
        logic active;
        logic [8:0] cnt;
        logic pulse_r;
    } rftx_pulse_st_t;

    // Timing block state
    typedef struct packed {
        logic [7:0] width_r;
        logic [2:0] one_len_r;
        logic [2:0] zero_len_r;
        logic [7:0] wctrl_r;
        logic [7:0] wlow_r;
        logic [7:0] rdata_r;
        rftx_wstate_t wstate_r;
        logic [10:0] wcnt_r;
        logic [3:0] presc_r;
        logic tx_ready_r;
        logic [8:0] burst_cnt_r;
        logic burst_r;
        logic burst_level_r;
        logic stop_bit_r;
        logic [2:0] guard_r;
    } rftx_st_t;
endpackage

/* rftx_pulse.sv */
// Modulation pulse shaper counting carrier periods
// Assumes start, bit end and carrier tick are one-cycle pulses on the same clock
`timescale 1ns/1ps
`include "rftx_consts.svh"
module rftx_pulse
    import rftx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic carrier_tick_in,
    input wire logic enable_in,
    input wire logic start_in,
    input wire logic bit_end_in,
    input wire logic [7:0] width_in,
    output logic pulse_out
);
    rftx_pulse_st_t st, st_nxt;

    // Next state of the pulse
    always_comb
    begin
        st_nxt = st;
        if (st.active && carrier_tick_in)
        begin
            st_nxt.cnt = st.cnt - 9'h001;
            if (st.cnt == 9'h001)
            begin
                st_nxt.active = 1'b0;
            end
        end
        if (bit_end_in)
        begin
            st_nxt.active = 1'b0;
        end
        if (start_in && enable_in)
        begin
            st_nxt.active = 1'b1;
            st_nxt.cnt = {1'b0, width_in} + 9'h001;
        end
        st_nxt.pulse_r = st_nxt.active;
    end

    // State register
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            st <= '0;
        else
            st <= st_nxt;
    end

    assign pulse_out = st.pulse_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_trunc;
        bit_end_in && !start_in |=> !pulse_out;
    endproperty
    a_trunc: assert property (p_trunc) else $error("pulse ran past bit end");

    property p_ignore;
        !enable_in && !pulse_out |=> !pulse_out;
    endproperty
    a_ignore: assert property (p_ignore) else $error("pulse without enable");

    sequence s_zero_start;
        start_in && enable_in && width_in == 8'h00 && !bit_end_in;
    endsequence
    property p_width0;
        s_zero_start ##1 (!start_in && !bit_end_in && carrier_tick_in) |=> !pulse_out;
    endproperty
    a_width0: assert property (p_width0) else $error("pulse not one carrier");
endmodule

/* rftx_timing.sv */
// Transmit timing controls: pulse width, burst length, wait time, stop and guard
// Assumes all strobes and ticks come from logic on MCLK_IN, one cycle each
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "rftx_consts.svh"
module rftx_timing
    import rftx_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    input wire logic CARRIER_TICK_IN,
    input wire logic HALF_BIT_TICK_IN,
    input wire logic BIT_TICK_IN,
    input wire logic PULSE_MOD_EN_IN,
    input wire logic MILLER_A_IN,
    input wire logic PULSE_START_IN,
    input wire logic BIT_END_IN,
    output logic MOD_PULSE_OUT,
    input wire logic BURST_START_IN,
    input wire logic BURST_SYM_IN,
    input wire logic BURST_LEVEL_SEL_IN,
    output logic BURST_OUT,
    output logic BURST_LEVEL_OUT,
    input wire logic TX_END_IN,
    input wire logic RX_END_IN,
    output logic TX_READY_OUT,
    input wire logic TYPE_B_IN,
    output logic STOP_BIT_OUT,
    output logic [2:0] GUARD_UNITS_OUT
);
    rftx_st_t st, st_nxt;
    logic wait_start;
    logic unit_tick;
    logic [10:0] wait_count;

    // Burst code to length in bits
    function automatic logic [8:0] burst_bits(input logic [2:0] code);
        case (code)
            3'h0: burst_bits = 9'h008;
            3'h1: burst_bits = 9'h010;
            3'h2: burst_bits = 9'h020;
            3'h3: burst_bits = 9'h030;
            3'h4: burst_bits = 9'h040;
            3'h5: burst_bits = 9'h060;
            3'h6: burst_bits = 9'h080;
            default: burst_bits = 9'h100;
        endcase
    endfunction

    // Wait origin, unit and count
    assign wait_start = st.wctrl_r[`RFTX_WC_ORIGIN] ? RX_END_IN : TX_END_IN;
    assign wait_count = {st.wctrl_r[`RFTX_WC_UP_HI:`RFTX_WC_UP_LO], st.wlow_r};
    assign unit_tick = st.wctrl_r[`RFTX_WC_UNIT] ? HALF_BIT_TICK_IN :
        (CARRIER_TICK_IN && st.presc_r == 4'(`RFTX_CARRIER_PER_UNIT - 1));

    // Next state: registers, wait, burst, stop and guard
    always_comb
    begin
        st_nxt = st;
        st_nxt.rdata_r = 8'h00;
        if (WR_IN)
        begin
            if (ADDR_IN == `RFTX_ADDR_PULSE)
                st_nxt.width_r = WDATA_IN;
            else if (ADDR_IN == `RFTX_ADDR_BURST)
            begin
                st_nxt.one_len_r = WDATA_IN[`RFTX_BL_ONE_HI:`RFTX_BL_ONE_LO];
                st_nxt.zero_len_r = WDATA_IN[`RFTX_BL_ZERO_HI:0];
            end
            else if (ADDR_IN == `RFTX_ADDR_WCTRL)
                st_nxt.wctrl_r = WDATA_IN;
            else if (ADDR_IN == `RFTX_ADDR_WLOW)
                st_nxt.wlow_r = WDATA_IN;
        end
        if (RD_IN)
        begin
            if (ADDR_IN == `RFTX_ADDR_PULSE)
                st_nxt.rdata_r = st.width_r;
            else if (ADDR_IN == `RFTX_ADDR_BURST)
                st_nxt.rdata_r = {1'b0, st.one_len_r, 1'b0, st.zero_len_r};
            else if (ADDR_IN == `RFTX_ADDR_WCTRL)
                st_nxt.rdata_r = st.wctrl_r;
            else if (ADDR_IN == `RFTX_ADDR_WLOW)
                st_nxt.rdata_r = st.wlow_r;
            else if (ADDR_IN == `RFTX_ADDR_STATUS)
                st_nxt.rdata_r = {5'h00, MOD_PULSE_OUT, st.burst_r, st.tx_ready_r};
        end
        // Carrier prescaler for sixteen-period units
        if (CARRIER_TICK_IN)
            st_nxt.presc_r = st.presc_r + 4'h1;
        // Wait interval before the next send
        case (st.wstate_r)
            RFTX_W_READY:
            begin
                if (wait_start && wait_count != 11'h000)
                begin
                    st_nxt.wstate_r = RFTX_W_COUNT;
                    st_nxt.wcnt_r = wait_count;
                    st_nxt.presc_r = 4'h0;
                end
            end
            RFTX_W_COUNT:
            begin
                if (wait_start)
                begin
                    st_nxt.wcnt_r = wait_count; // Restart on a new origin event
                    st_nxt.presc_r = 4'h0;
                    if (wait_count == 11'h000)
                        st_nxt.wstate_r = RFTX_W_READY;
                end
                else if (unit_tick)
                begin
                    st_nxt.wcnt_r = st.wcnt_r - 11'h001;
                    if (st.wcnt_r == 11'h001)
                        st_nxt.wstate_r = RFTX_W_READY;
                end
            end
            default: st_nxt.wstate_r = RFTX_W_READY;
        endcase
        st_nxt.tx_ready_r = (st_nxt.wstate_r == RFTX_W_READY);
        // Burst length in bit periods
        if (BURST_START_IN)
        begin
            st_nxt.burst_cnt_r = burst_bits(BURST_SYM_IN ? st.one_len_r : st.zero_len_r);
            st_nxt.burst_level_r = BURST_LEVEL_SEL_IN;
        end
        else if (BIT_TICK_IN && st.burst_cnt_r != 9'h000)
            st_nxt.burst_cnt_r = st.burst_cnt_r - 9'h001;
        st_nxt.burst_r = (st_nxt.burst_cnt_r != 9'h000);
        // Stop bit and extra guard units for Type B
        st_nxt.stop_bit_r = TYPE_B_IN && st.wctrl_r[`RFTX_WC_STOP_HI:0] != 3'h0;
        st_nxt.guard_r = 3'h0;
        if (TYPE_B_IN && st.wctrl_r[`RFTX_WC_STOP_HI:0] > 3'h1)
            st_nxt.guard_r = st.wctrl_r[`RFTX_WC_STOP_HI:0] - 3'h1;
    end

    // State register with synchronous reset
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            st <= '0;
            st.wctrl_r <= `RFTX_RST_WCTRL;
            st.wstate_r <= RFTX_W_READY;
            st.tx_ready_r <= 1'b1;
        end
        else
            st <= st_nxt;
    end

    // Pulse shaper, gated to Miller Type A
    rftx_pulse u_pulse (
        .clk_in(MCLK_IN),
        .rst_n_in(RST_N_IN),
        .carrier_tick_in(CARRIER_TICK_IN),
        .enable_in(PULSE_MOD_EN_IN && MILLER_A_IN),
        .start_in(PULSE_START_IN),
        .bit_end_in(BIT_END_IN),
        .width_in(st.width_r),
        .pulse_out(MOD_PULSE_OUT)
    );

    // Outputs straight from the state flops
    assign RDATA_OUT = st.rdata_r;
    assign TX_READY_OUT = st.tx_ready_r;
    assign BURST_OUT = st.burst_r;
    assign BURST_LEVEL_OUT = st.burst_level_r;
    assign STOP_BIT_OUT = st.stop_bit_r;
    assign GUARD_UNITS_OUT = st.guard_r;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);

    property p_origin_tx;
        TX_READY_OUT && TX_END_IN && !st.wctrl_r[7] && wait_count != 11'h000 |=> !TX_READY_OUT;
    endproperty
    a_origin_tx: assert property (p_origin_tx) else $error("send end did not start wait");

    property p_origin_rx;
        TX_READY_OUT && st.wctrl_r[7] && !RX_END_IN |=> TX_READY_OUT;
    endproperty
    a_origin_rx: assert property (p_origin_rx) else $error("wait started off origin");

    property p_load;
        TX_READY_OUT && wait_start && wait_count != 11'h000 |=> st.wcnt_r == $past(wait_count);
    endproperty
    a_load: assert property (p_load) else $error("wait count not loaded");

    property p_carrier_unit;
        st.wstate_r == RFTX_W_COUNT && !wait_start && !st.wctrl_r[6] && !CARRIER_TICK_IN
            |=> $stable(st.wcnt_r);
    endproperty
    a_carrier_unit: assert property (p_carrier_unit) else $error("wait moved off carrier");

    property p_half_unit;
        st.wstate_r == RFTX_W_COUNT && !wait_start && st.wctrl_r[6] && HALF_BIT_TICK_IN
            |=> st.wcnt_r == $past(st.wcnt_r) - 11'h001;
    endproperty
    a_half_unit: assert property (p_half_unit) else $error("half bit tick not counted");

    sequence s_burst_zero;
        BURST_START_IN && !BURST_SYM_IN && st.zero_len_r == 3'h7;
    endsequence
    property p_burst_len;
        s_burst_zero |=> BURST_OUT && st.burst_cnt_r == 9'h100;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst code 7 not 256");

    property p_burst_level;
        BURST_OUT && !BURST_START_IN |=> $stable(BURST_LEVEL_OUT);
    endproperty
    a_burst_level: assert property (p_burst_level) else $error("burst level moved");

    property p_type_a;
        !TYPE_B_IN |=> !STOP_BIT_OUT && GUARD_UNITS_OUT == 3'h0;
    endproperty
    a_type_a: assert property (p_type_a) else $error("stop bits outside Type B");

    property p_guard;
        TYPE_B_IN && st.wctrl_r[2:0] == 3'h7 |=> STOP_BIT_OUT && GUARD_UNITS_OUT == 3'h6;
    endproperty
    a_guard: assert property (p_guard) else $error("guard units wrong");

    property p_reset_val;
        $rose(RST_N_IN) |-> st.wctrl_r == 8'hc0;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("wait control reset wrong");

    // Prescaler restarts with every loaded wait
    property p_load_prescale;
        TX_READY_OUT && wait_start && wait_count != 11'h000 |=> st.presc_r == 4'h0;
    endproperty
    a_load_prescale: assert property (p_load_prescale) else $error("prescaler not cleared");

    property p_zero_count;
        TX_READY_OUT && wait_start && wait_count == 11'h000 |=> TX_READY_OUT;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero count blocked send");

    // Send stays blocked until the last unit has passed
    property p_wait_hold;
        !TX_READY_OUT && !wait_start && !unit_tick |=> !TX_READY_OUT;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait ended early");

    property p_wait_end;
        !TX_READY_OUT && !wait_start && unit_tick && st.wcnt_r == 11'h001 |=> TX_READY_OUT;
    endproperty
    a_wait_end: assert property (p_wait_end) else $error("wait did not end");

    property p_restart;
        !TX_READY_OUT && wait_start && wait_count != 11'h000
            |=> !TX_READY_OUT && st.wcnt_r == $past(wait_count);
    endproperty
    a_restart: assert property (p_restart) else $error("origin event did not restart");

    property p_carrier_count;
        !TX_READY_OUT && !wait_start && !st.wctrl_r[6] && unit_tick
            |=> st.wcnt_r == $past(st.wcnt_r) - 11'h001;
    endproperty
    a_carrier_count: assert property (p_carrier_count) else $error("carrier unit lost");

    // Symbol one field decodes with the zero map
    sequence s_burst_one;
        BURST_START_IN && BURST_SYM_IN && st.one_len_r == 3'h3;
    endsequence
    property p_burst_one;
        s_burst_one |=> BURST_OUT && st.burst_cnt_r == 9'h030;
    endproperty
    a_burst_one: assert property (p_burst_one) else $error("symbol one code 3 not 48");

    property p_burst_end;
        BURST_OUT && !BURST_START_IN && BIT_TICK_IN && st.burst_cnt_r == 9'h001 |=> !BURST_OUT;
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("burst overran");

    // Read-back of the register fields
    property p_read_burst;
        RD_IN && ADDR_IN == `RFTX_ADDR_BURST |=> RDATA_OUT[7] == 1'b0 && RDATA_OUT[3] == 1'b0;
    endproperty
    a_read_burst: assert property (p_read_burst) else $error("burst spare bits set");

    property p_read_wlow;
        RD_IN && ADDR_IN == `RFTX_ADDR_WLOW |=> RDATA_OUT == $past(st.wlow_r);
    endproperty
    a_read_wlow: assert property (p_read_wlow) else $error("low wait byte misread");

    property p_read_idle;
        !RD_IN |=> RDATA_OUT == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outlived strobe");

    // Stop codes 0 and 1 under Type B framing
    property p_stop_one;
        TYPE_B_IN && st.wctrl_r[2:0] == 3'h1 |=> STOP_BIT_OUT && GUARD_UNITS_OUT == 3'h0;
    endproperty
    a_stop_one: assert property (p_stop_one) else $error("code 1 not lone stop bit");

    property p_stop_none;
        TYPE_B_IN && st.wctrl_r[2:0] == 3'h0 |=> !STOP_BIT_OUT;
    endproperty
    a_stop_none: assert property (p_stop_none) else $error("code 0 gave stop bit");
endmodule

/* tb_rftx_timing.sv */
// Self-checking bench for the transmit timing block
// Assumes the field model supplies ticks; registers driven over the plain port
`timescale 1ns/1ps
`define CHK(got, exp) chk((got) === (exp));
module tb_rftx_timing;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic pen = 1'b1, mil = 1'b1, pstart = 1'b0, bend = 1'b0, bstart = 1'b0;
    logic bsym = 1'b0, blev = 1'b0, tx_end = 1'b0, rx_req = 1'b0, type_b = 1'b0;
    logic ctick, htick, btick, rx_end, mod_pulse, burst, burst_lev, tx_ready, stop_bit;
    logic lev0;
    logic [2:0] guard;
    int errors = 0, num_checks = 0, n;
    int len[8] = '{8, 16, 32, 48, 64, 96, 128, 256};

    // Clock, 25 ns period
    always #12.5 clk = ~clk;

    rftx_timing i_rftx_timing (.MCLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .CARRIER_TICK_IN(ctick), .HALF_BIT_TICK_IN(htick), .BIT_TICK_IN(btick),
        .PULSE_MOD_EN_IN(pen), .MILLER_A_IN(mil), .PULSE_START_IN(pstart),
        .BIT_END_IN(bend), .MOD_PULSE_OUT(mod_pulse), .BURST_START_IN(bstart),
        .BURST_SYM_IN(bsym), .BURST_LEVEL_SEL_IN(blev), .BURST_OUT(burst),
        .BURST_LEVEL_OUT(burst_lev), .TX_END_IN(tx_end), .RX_END_IN(rx_end),
        .TX_READY_OUT(tx_ready), .TYPE_B_IN(type_b), .STOP_BIT_OUT(stop_bit),
        .GUARD_UNITS_OUT(guard));
    rftx_field_model i_rftx_field_model (.clk_in(clk), .rst_n_in(rst_n),
        .rx_req_in(rx_req), .carrier_tick_out(ctick), .half_bit_tick_out(htick),
        .bit_tick_out(btick), .rx_end_out(rx_end));

    // Count and report comparisons
    task chk(input bit ok);
        num_checks++;
        if (!ok)
        begin
            errors++;
            $display("FAIL %0t value mismatch", $time);
        end
    endtask

    // Verdict and end of run
    task end_sim;
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Register write and read cycles
    task wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // One-cycle event: 0 pulse start, 1 burst start, 2 send end, 3 receive end
    task automatic event1(input int w);
        @(posedge clk);
        case (w)
            0: pstart <= 1'b1;
            1: bstart <= 1'b1;
            2: tx_end <= 1'b1;
            default: rx_req <= 1'b1;
        endcase
        @(posedge clk);
        {pstart, bstart, tx_end, rx_req} <= 4'h0;
        if (w == 3)
            @(posedge clk);
    endtask

    // Ticks seen while an output is active: pulse, burst, wait by carrier, by half bit
    task automatic measure(input int sel);
        logic o, t;
        n = 0;
        for (int k = 0; k < 20000; k++)
        begin
            @(negedge clk);
            if (k == 0)
                lev0 = burst_lev;
            o = (sel == 0) ? mod_pulse : (sel == 1) ? burst : !tx_ready;
            t = (sel == 0 || sel == 2) ? ctick : (sel == 1) ? btick : htick;
            if (o !== 1'b1)
                break;
            if (t)
                n++;
        end
    endtask

    // Let a few cycles pass, then sample
    task settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    // Reset values, read-only bits, unmapped address
    task t_regs;
        rd_reg(8'h31);
        `CHK(d, 8'hc0)
        @(posedge clk);
        @(negedge clk);
        `CHK(rdata, 8'h00)
        wr_reg(8'h30, 8'hff);
        rd_reg(8'h30);
        `CHK(d, 8'h77)
        wr_reg(8'h2f, 8'ha5);
        wr_reg(8'h32, 8'h5a);
        wr_reg(8'h31, 8'h3f);
        rd_reg(8'h2f);
        `CHK(d, 8'ha5)
        rd_reg(8'h32);
        `CHK(d, 8'h5a)
        rd_reg(8'h31);
        `CHK(d, 8'h3f)
        wr_reg(8'h10, 8'h55);
        rd_reg(8'h10);
        `CHK(d, 8'h00)
    endtask

    // Pulse length, mode gating, truncation at bit end
    task t_pulse;
        wr_reg(8'h2f, 8'h02);
        event1(0);
        measure(0);
        `CHK(n, 3)
        wr_reg(8'h2f, 8'h00);
        event1(0);
        measure(0);
        `CHK(n, 1)
        @(posedge clk);
        mil <= 1'b0;
        event1(0);
        @(negedge clk);
        `CHK(mod_pulse, 1'b0)
        @(posedge clk);
        mil <= 1'b1;
        pen <= 1'b0;
        event1(0);
        @(negedge clk);
        `CHK(mod_pulse, 1'b0)
        @(posedge clk);
        pen <= 1'b1;
        wr_reg(8'h2f, 8'hff);
        event1(0);
        settle;
        `CHK(mod_pulse, 1'b1)
        rd_reg(8'h3f);
        `CHK(d, 8'h05)
        @(posedge clk);
        bend <= 1'b1;
        @(posedge clk);
        bend <= 1'b0;
        @(negedge clk);
        `CHK(mod_pulse, 1'b0)
    endtask

    // Every burst code on both symbols, level captured at start
    task t_burst;
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(8'h30, {1'b0, 3'(c), 1'b0, ~3'(c)});
            for (int s = 0; s < 2; s++)
            begin
                @(posedge clk);
                bsym <= 1'(s);
                blev <= 1'(c ^ s);
                event1(1);
                measure(1);
                `CHK(n, len[s ? c : 7 - c])
                `CHK(lev0, 1'(c ^ s))
            end
        end
    endtask

    // Wait origin, units, eleven-bit count, zero count
    task t_wait;
        wr_reg(8'h32, 8'h03);
        wr_reg(8'h31, 8'h00);
        event1(3);
        settle;
        `CHK(tx_ready, 1'b1)
        event1(2);
        measure(2);
        `CHK(n, 48)
        wr_reg(8'h32, 8'h01);
        wr_reg(8'h31, 8'h60);
        event1(2);
        measure(3);
        `CHK(n, 1025)
        wr_reg(8'h32, 8'h05);
        wr_reg(8'h31, 8'hc0);
        event1(2);
        settle;
        `CHK(tx_ready, 1'b1)
        event1(3);
        measure(3);
        `CHK(n, 5)
        wr_reg(8'h32, 8'h00);
        event1(3);
        settle;
        `CHK(tx_ready, 1'b1)
    endtask

    // Stop and guard codes with and without Type B framing
    task t_stop;
        @(posedge clk);
        type_b <= 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(8'h31, {5'h18, 3'(c)});
            @(posedge clk);
            @(negedge clk);
            `CHK(stop_bit, c != 0)
            `CHK(guard, (c > 1) ? 3'(c - 1) : 3'h0)
        end
        @(posedge clk);
        type_b <= 1'b0;
        settle;
        `CHK({stop_bit, guard}, 4'h0)
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_pulse;
        t_burst;
        t_wait;
        t_stop;
        end_sim;
    end

    // Hang guard, well beyond the longest expected run
    initial
    begin
        repeat (40000) @(posedge clk);
        errors++;
        end_sim;
    end
endmodule
